//--- common/aps_regs.vh
// Function
// - reading a pin-state register returns low for every bit whose pin is in analog mode.
// - a select bit of 1 puts its pin in analog mode with port reads off, 0 puts it in digital mode.
// - every implemented select bit is read/write and comes out of reset at 1.
// - unimplemented select bit positions read as zero and ignore writes.
// - the port A select register implements only bits 10-9 and 7-6.
// - the port B select register implements all bits 15-0.
// - the port C select register implements only bits 14-13 and 4.
// - the port D select register implements only bits 7-6.
// - select and direction together give analog, digital input or digital output pin function.
// - the reduced pin-count variant has no port A select register and no port C bit 4.
// - a direction bit of 1 makes its pin an input, and every pin resets as an input.
// - reading the pin-state register samples the pins, writing it updates the output latch.
`ifndef APS_REGS_VH
`define APS_REGS_VH

`define APS_OFS_SEL_A   12'h000
`define APS_OFS_SEL_B   12'h004
`define APS_OFS_SEL_C   12'h008
`define APS_OFS_SEL_D   12'h00c
`define APS_OFS_DIR_A   12'h010
`define APS_OFS_PIN_A   12'h020
`define APS_OFS_LAT_A   12'h030

`define APS_MASK_A      16'h06c0
`define APS_MASK_B      16'hffff
`define APS_MASK_C      16'h6010
`define APS_MASK_C_RED  16'h6000
`define APS_MASK_D      16'h00c0
`define APS_MASK_NONE   16'h0000

`define APS_SEL_RST     16'hffff
`define APS_DIR_RST     16'hffff
`define APS_LAT_RST     16'h0000

`define APS_RESP_OKAY   2'b00
`define APS_RESP_SLVERR 2'b10

`endif

//--- rtl/aps_port_bit.v
`timescale 1ns/1ps
// one port: pin input synchroniser, output drive and analog read masking
module aps_port_bit
(
   // clock and reset
   input  wire        clk,
   input  wire        rst_b,
   // configuration
   input  wire [15:0] sel,
   input  wire [15:0] dir,
   input  wire [15:0] lat,
   input  wire [15:0] impl,
   // pins
   input  wire [15:0] pin_in,
   output reg  [15:0] pin_out,
   output reg  [15:0] pin_oe,
   output reg  [15:0] analog_en,
   // value seen by a port read
   output wire [15:0] port_read
);
   reg [15:0] sync1_reg;
   reg [15:0] sync2_reg;

   always @(posedge clk)
   begin
      if (!rst_b)
      begin
         sync1_reg <= 16'h0000;
         sync2_reg <= 16'h0000;
         pin_out   <= 16'h0000;
         pin_oe    <= 16'h0000;
         analog_en <= 16'h0000;
      end
      else
      begin
         sync1_reg <= pin_in;
         sync2_reg <= sync1_reg;
         pin_out   <= lat & impl;
         pin_oe    <= ~dir & ~sel & impl;
         analog_en <= sel & impl;
      end
   end

   assign port_read = sync2_reg & ~sel & impl;
endmodule

//--- rtl/aps_analog_select.v
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "aps_regs.vh"
module aps_analog_select
#(
   parameter REDUCED_PINS = 0
)
(
   // clock and reset
   input  wire        clk,
   input  wire        rst_b,
   // axi4-lite write address
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   // axi4-lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   // axi4-lite write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // axi4-lite read address
   input  wire [11:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   // axi4-lite read data
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // port pins, four ports of 16 packed a..d from low
   input  wire [63:0] pin_in,
   output wire [63:0] pin_out,
   output wire [63:0] pin_oe,
   output wire [63:0] analog_en
);
   localparam [15:0] MASK_A = REDUCED_PINS ? `APS_MASK_NONE : `APS_MASK_A;
   localparam [15:0] MASK_C = REDUCED_PINS ? `APS_MASK_C_RED : `APS_MASK_C;
   localparam [63:0] SEL_MASK = {`APS_MASK_D, MASK_C, `APS_MASK_B, MASK_A};
   // port A pins themselves are absent in the reduced variant too
   localparam [15:0] IMPL_A = REDUCED_PINS ? 16'h0000 : 16'hffff;
   localparam [63:0] IMPL = {16'hffff, 16'hffff, 16'hffff, IMPL_A};

   reg  [63:0] sel_reg;
   reg  [63:0] dir_reg;
   reg  [63:0] lat_reg;
   reg  [11:0] aw_addr_reg;
   reg         aw_have_reg;
   reg  [31:0] w_data_reg;
   reg  [3:0]  w_strb_reg;
   reg         w_have_reg;
   wire [63:0] port_read;

   // register group 0..3 for select, 4..7 direction, 8..11 pin state, 12..15 latch
   function [4:0] reg_decode;
      input [11:0] addr;
      begin
         if (addr[11:6] == 6'h00 && addr[1:0] == 2'b00)
            reg_decode = {1'b1, addr[5:2]};
         else
            reg_decode = 5'h00;
      end
   endfunction

   // merges 16-bit write data into one port field under byte strobes
   function [15:0] merge16;
      input [15:0] old;
      input [15:0] data;
      input [1:0]  strb;
      input [15:0] mask;
      begin
         merge16 = old;
         if (strb[0])
            merge16[7:0] = data[7:0];
         if (strb[1])
            merge16[15:8] = data[15:8];
         merge16 = merge16 & mask;
      end
   endfunction

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : port
         aps_port_bit u_port
         (
            .clk       (clk),
            .rst_b     (rst_b),
            .sel       (sel_reg[16*g +: 16]),
            .dir       (dir_reg[16*g +: 16]),
            .lat       (lat_reg[16*g +: 16]),
            .impl      (IMPL[16*g +: 16]),
            .pin_in    (pin_in[16*g +: 16]),
            .pin_out   (pin_out[16*g +: 16]),
            .pin_oe    (pin_oe[16*g +: 16]),
            .analog_en (analog_en[16*g +: 16]),
            .port_read (port_read[16*g +: 16])
         );
      end
   endgenerate

   wire       wr_go  = aw_have_reg && w_have_reg && !s_axi_bvalid;
   wire [4:0] wr_dec = reg_decode(aw_addr_reg);
   wire [1:0] wr_prt = wr_dec[1:0];
   wire [4:0] rd_dec = reg_decode(s_axi_araddr);
   wire [1:0] rd_prt = rd_dec[1:0];

   // write channel capture, address and data in either order
   always @(posedge clk)
   begin
      if (!rst_b)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         aw_addr_reg   <= 12'h000;
         aw_have_reg   <= 1'b0;
         w_data_reg    <= 32'h00000000;
         w_strb_reg    <= 4'h0;
         w_have_reg    <= 1'b0;
      end
      else
      begin
         s_axi_awready <= !aw_have_reg && !s_axi_awready && !wr_go;
         s_axi_wready  <= !w_have_reg && !s_axi_wready && !wr_go;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_addr_reg <= s_axi_awaddr;
            aw_have_reg <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         else if (wr_go)
            aw_have_reg <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
            w_have_reg <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         else if (wr_go)
            w_have_reg <= 1'b0;
      end
   end

   // register writes and write response
   always @(posedge clk)
   begin
      if (!rst_b)
      begin
         sel_reg      <= {`APS_SEL_RST, `APS_SEL_RST, `APS_SEL_RST, `APS_SEL_RST} & SEL_MASK;
         dir_reg      <= {`APS_DIR_RST, `APS_DIR_RST, `APS_DIR_RST, `APS_DIR_RST} & IMPL;
         lat_reg      <= {4{`APS_LAT_RST}};
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `APS_RESP_OKAY;
      end
      else
      begin
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (wr_go)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_dec[4] ? `APS_RESP_OKAY : `APS_RESP_SLVERR;
            if (wr_dec[4])
            begin
               case (wr_dec[3:2])
                  2'd0: sel_reg[16*wr_prt +: 16] <= merge16(sel_reg[16*wr_prt +: 16],
                        w_data_reg[15:0], w_strb_reg[1:0], SEL_MASK[16*wr_prt +: 16]);
                  2'd1: dir_reg[16*wr_prt +: 16] <= merge16(dir_reg[16*wr_prt +: 16],
                        w_data_reg[15:0], w_strb_reg[1:0], IMPL[16*wr_prt +: 16]);
                  // pin-state write goes to the latch
                  2'd2: lat_reg[16*wr_prt +: 16] <= merge16(lat_reg[16*wr_prt +: 16],
                        w_data_reg[15:0], w_strb_reg[1:0], IMPL[16*wr_prt +: 16]);
                  default: lat_reg[16*wr_prt +: 16] <= merge16(lat_reg[16*wr_prt +: 16],
                        w_data_reg[15:0], w_strb_reg[1:0], IMPL[16*wr_prt +: 16]);
               endcase
            end
         end
      end
   end

   // read channel, one cycle from address taken to data valid
   always @(posedge clk)
   begin
      if (!rst_b)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `APS_RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
         if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= rd_dec[4] ? `APS_RESP_OKAY : `APS_RESP_SLVERR;
            if (!rd_dec[4])
               s_axi_rdata <= 32'h00000000;
            else
            begin
               case (rd_dec[3:2])
                  2'd0: s_axi_rdata <= {16'h0000, sel_reg[16*rd_prt +: 16]};
                  2'd1: s_axi_rdata <= {16'h0000, dir_reg[16*rd_prt +: 16]};
                  2'd2: s_axi_rdata <= {16'h0000, port_read[16*rd_prt +: 16]};
                  default: s_axi_rdata <= {16'h0000, lat_reg[16*rd_prt +: 16]};
               endcase
            end
         end
      end
   end
endmodule

//--- testbench/aps_monitor.sv
`timescale 1ns/1ps
module aps_monitor
(
   // clock and reset
   input wire        clk,
   input wire        rst_b,
   // write channels
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   // read channels
   input wire [11:0] s_axi_araddr,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0]  s_axi_rresp,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   // pins
   input wire [63:0] pin_oe,
   input wire [63:0] analog_en
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire ar_go;
   wire bad_ar;
   assign ar_go = s_axi_arvalid & s_axi_arready;
   assign bad_ar = (s_axi_araddr > 12'h03f) | (s_axi_araddr[1:0] != 2'b00);
   hold_wr_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   hold_rd_a: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
      else $error("read data changed while waiting");
   rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("read data upper half not zero");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address accepted with data pending");
   rd_answer_a: assert property (ar_go |-> ##[1:2] s_axi_rvalid)
      else $error("read not answered in time");
   bad_rd_a: assert property (ar_go && bad_ar |-> ##[1:2] (s_axi_rvalid && s_axi_rresp == 2'b10))
      else $error("unmapped read not refused");
   wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid)
      else $error("write not answered in time");
   oe_analog_a: assert property ((pin_oe & analog_en) == 64'h0)
      else $error("analog pin driven as output");
   unimpl_a_a: assert property ((analog_en[15:0] & ~16'h06c0) == 16'h0)
      else $error("port a unimplemented pin analog");
   unimpl_cd_a: assert property ((analog_en[63:32] & ~32'h00c0_6010) == 32'h0)
      else $error("port c or d unimplemented pin analog");
   cover property (ar_go && bad_ar);
   cover property ($fell(analog_en[16]));
   cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind aps_analog_select aps_monitor mon_u (.clk(clk), .rst_b(rst_b),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pin_oe(pin_oe),
   .analog_en(analog_en));

//--- testbench/analog_pin_select_tb.sv
`timescale 1ns/1ps
module analog_pin_select_tb;
   reg         clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
   reg  [11:0] awaddr, araddr;
   reg  [31:0] wdata;
   reg  [63:0] pin_in;
   wire        awready, wready, bvalid, arready, rvalid;
   wire [1:0]  bresp, rresp;
   wire [31:0] rdata;
   wire [63:0] pin_out, pin_oe, analog_en;
   reg  [15:0] r, s, d, l, pv;
   integer     miscompares, tests_run, cycles, p, k;
   aps_analog_select #(.REDUCED_PINS(0)) dut_u (.clk(clk), .rst_b(rst_b),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .analog_en(analog_en));
   function [15:0] lfsr(input [15:0] x);
      lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   function [15:0] msk(input integer q);
      msk = (q == 0) ? 16'h06c0 : (q == 1) ? 16'hffff : (q == 2) ? 16'h6010 : 16'h00c0;
   endfunction
   // bits of analog pins are forced low
   function [15:0] lowed(input [15:0] v, input [15:0] sel, input [15:0] m);
      lowed = v & ~(sel & m);
   endfunction
   task close_out;
      begin
         if (miscompares == 0 && tests_run > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         tests_run = tests_run + 1;
         if (seen !== exp)
         begin
            miscompares = miscompares + 1;
            $display("Error t=%0t seen %h exp %h", $time, seen, exp);
         end
      end
   endtask
   task wr(input [11:0] a, input [15:0] v, input [1:0] er);
      begin
         @(posedge clk);
         awaddr <= a;
         wdata <= {16'h0000, v};
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         do
         begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
         end while (!bvalid);
         bready <= 1'b0;
         chk(bresp, er);
      end
   endtask
   task rd(input [11:0] a, input [15:0] e, input [1:0] er);
      begin
         @(posedge clk);
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         do
         begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
         end while (!rvalid);
         rready <= 1'b0;
         chk(rdata, {16'h0000, e});
         chk(rresp, er);
      end
   endtask
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles = cycles + 1;
      if (cycles == 3000)
      begin
         miscompares = miscompares + 1;
         close_out;
      end
   end
   initial
   begin
      {rst_b, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {awaddr, araddr, wdata, pin_in} = 0;
      miscompares = 0;
      tests_run = 0;
      cycles = 0;
      r = 16'h003b;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      for (p = 0; p < 4; p = p + 1)
      begin
         rd(p * 4, msk(p), 2'b00);
         rd(12'h010 + p * 4, 16'hffff, 2'b00);
         chk(pin_oe[p * 16 +: 16], 16'h0000);
      end
      rd(12'h100, 16'h0000, 2'b10);
      wr(12'h102, 16'hffff, 2'b10);
      // analog pass keeps select at 1
      // digital outputs only after analog select cleared
      // all-digital, all-analog, then random selects
      for (k = 0; k < 4; k = k + 1)
         for (p = 0; p < 4; p = p + 1)
         begin
            r = lfsr(r);
            s = (k == 0) ? 16'h0000 : (k == 1) ? 16'hffff : r;
            r = lfsr(r);
            d = r;
            r = lfsr(r);
            l = r;
            r = lfsr(r);
            pv = r;
            pin_in[p * 16 +: 16] <= pv;
            wr(p * 4, s, 2'b00);
            wr(12'h010 + p * 4, d, 2'b00);
            wr(12'h030 + p * 4, l, 2'b00);
            rd(p * 4, s & msk(p), 2'b00);
            repeat (4) @(posedge clk);
            rd(12'h020 + p * 4, lowed(pv, s, msk(p)), 2'b00);
            chk(analog_en[p * 16 +: 16], s & msk(p));
            chk(pin_oe[p * 16 +: 16], lowed(~d, s, msk(p)));
            chk(pin_out[p * 16 +: 16], l);
         end
      close_out;
   end
endmodule
